// ---- rtl/jtp_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none

module jtp_fifo
  import jtp_pkg::*;
#(
  parameter int WIDTH = BSR_LEN_DEF,
  parameter int DEPTH = FIFO_DEPTH_DEF
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  // pointer arithmetic relies on wrap at a power of two
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
    $error("jtp_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  // full when pointers differ only in the wrap bit
  assign in_ready  = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage, written only on an accepted push
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ---- rtl/jtp_pkg.sv ----
package jtp_pkg;

  // controller states, binary codes written out
  typedef enum logic [3:0] {
    ST_RESET     = 4'h0,
    ST_IDLE      = 4'h1,
    ST_SEL_DR    = 4'h2,
    ST_CAP_DR    = 4'h3,
    ST_SHIFT_DR  = 4'h4,
    ST_EXIT1_DR  = 4'h5,
    ST_PAUSE_DR  = 4'h6,
    ST_EXIT2_DR  = 4'h7,
    ST_UPD_DR    = 4'h8,
    ST_SEL_IR    = 4'h9,
    ST_CAP_IR    = 4'ha,
    ST_SHIFT_IR  = 4'hb,
    ST_EXIT1_IR  = 4'hc,
    ST_PAUSE_IR  = 4'hd,
    ST_EXIT2_IR  = 4'he,
    ST_UPD_IR    = 4'hf
  } jtp_state_t;

  // instruction register layout and codes
  localparam int         IR_LEN       = 3;
  localparam logic [2:0] INS_EXTEST   = 3'h0;
  localparam logic [2:0] INS_IDCODE   = 3'h1;
  localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
  localparam logic [2:0] INS_SAMPLE   = 3'h4;
  localparam logic [2:0] INS_BYPASS   = 3'h7;
  localparam logic [2:0] IR_RESET_VAL = INS_IDCODE;

  // data register sizes and fixed values
  localparam int   ID_LEN           = 32;
  localparam int   BSR_LEN_DEF      = 129;
  localparam logic BYPASS_CAP_VAL   = 1'b0;
  localparam logic INT_CELL_CAP_VAL = 1'b1;
  localparam int   TMS_RESET_EDGES  = 5;
  localparam int   FIFO_DEPTH_DEF   = 16;

  // pin group sampled from outside the clock domain
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtp_pins_t;

endpackage

// ---- rtl/jtp_tap.sv ----
// Functional notes
// - sixteen states, tms steered, tck rising only
// - five tms-high edges or reset reach reset
// - tdi used only in shift states
// - tdo enabled only in shift states
// - shift on tck rise, tdo on fall
// - three-bit instruction preset to idcode
// - new instruction acts at update-ir only
// - decode extest idcode highz-sample sample bypass
// - boundary instructions capture and shift i/o ring
// - extest drives pins, new data at update-dr; queued word reaches pins once pin_ready drains it, unless overwritten while the queue is full
// - extest and highz-sample disable termination
// - highz-sample forces data drivers high impedance
// - idcode captures and shifts identification register
// - bypass captures zero, one-stage path
// - other instructions leave memory operation alone
// - id 32 bits, bit0 one, lsb first
// - extest internal cell enables data drivers
`timescale 1ns/1ps
`default_nettype none

module jtp_tap
  import jtp_pkg::*;
#(
  parameter int          BSR_LEN    = BSR_LEN_DEF,
  parameter int          FIFO_DEPTH = FIFO_DEPTH_DEF,
  parameter logic [31:0] ID_CODE    = 32'h1234_5a5b  // arbitrary value, bit 0 set
) (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               sys_rst,
  // test port pins
  input  wire logic               tck_pin,
  input  wire logic               tms_pin,
  input  wire logic               tdi_pin,
  output logic                    tdo_out,
  output logic                    tdo_oe,
  // i/o ring sampling, one level per pad cell
  input  wire logic [BSR_LEN-2:0] io_ring_levels,
  // boundary pin drive stage
  input  wire logic               pin_ready,
  output logic [BSR_LEN-2:0]      boundary_pin_values,
  output logic                    extest_override,
  output logic                    dq_drive_enable,
  output logic                    dq_force_hiz,
  output logic                    on_die_termination_off,
  output logic                    functional_undisturbed
);

  // the internal cell sits above the pad cells, so at least one pad is needed
  if (BSR_LEN < 2 || ID_CODE[0] != 1'b1 || FIFO_DEPTH < 2) begin : g_bad_param
    $error("jtp_tap: bad BSR_LEN, ID_CODE or FIFO_DEPTH");
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and tck edge detection
  jtp_pins_t  sync1_reg;
  jtp_pins_t  sync2_reg;
  logic       tck_prev_reg;
  logic       tck_rise;
  logic       tck_fall;

  // pins come from the tester's domain; first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= '{tck: tck_pin, tms: tms_pin, tdi: tdi_pin};
      sync2_reg <= sync1_reg;
    end
  end

  // previous tck level for edge finding
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tck_prev_reg <= 1'b0;
    end else begin
      tck_prev_reg <= sync2_reg.tck;
    end
  end

  assign tck_rise = sync2_reg.tck && !tck_prev_reg;
  assign tck_fall = !sync2_reg.tck && tck_prev_reg;

  //////////////////////////////////////////////////////////////////////////////
  // controller
  jtp_state_t state_reg;
  jtp_state_t state_next;

  // next state from the usual graph, tms picks the branch
  always_comb begin
    unique case (state_reg)
      ST_RESET:    state_next = sync2_reg.tms ? ST_RESET    : ST_IDLE;
      ST_IDLE:     state_next = sync2_reg.tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   state_next = sync2_reg.tms ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   state_next = sync2_reg.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_next = sync2_reg.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_next = sync2_reg.tms ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: state_next = sync2_reg.tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_next = sync2_reg.tms ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   state_next = sync2_reg.tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   state_next = sync2_reg.tms ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   state_next = sync2_reg.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_next = sync2_reg.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_next = sync2_reg.tms ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: state_next = sync2_reg.tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_next = sync2_reg.tms ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   state_next = sync2_reg.tms ? ST_SEL_DR   : ST_IDLE;
    endcase
  end

  // moves only on a tck rise; power-up reset lands in the reset state
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= ST_RESET;
    end else if (tck_rise) begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // instruction register and decode
  logic [IR_LEN-1:0] ir_shift_reg;
  logic [IR_LEN-1:0] test_instruction_reg;
  logic              ins_extest;
  logic              ins_samplez;
  logic              sel_bsr;
  logic              sel_id;
  logic              shift_ir;
  logic              shift_dr;

  assign shift_ir = state_reg == ST_SHIFT_IR;
  assign shift_dr = state_reg == ST_SHIFT_DR;

  // shift stage: preset in reset and capture, tdi into msb while shifting
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ir_shift_reg <= IR_RESET_VAL;
    end else if (tck_rise) begin
      if (state_reg == ST_RESET || state_reg == ST_CAP_IR) begin
        ir_shift_reg <= IR_RESET_VAL;
      end else if (shift_ir) begin
        ir_shift_reg <= {sync2_reg.tdi, ir_shift_reg[IR_LEN-1:1]};
      end
    end
  end

  // the instruction in effect changes only at update-ir or reset; the preset lands
  // on the rise that enters reset, so the reset state already decodes idcode
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      test_instruction_reg <= IR_RESET_VAL;
    end else if (tck_rise) begin
      if (state_next == ST_RESET) begin
        test_instruction_reg <= IR_RESET_VAL;
      end else if (state_reg == ST_UPD_IR) begin
        test_instruction_reg <= ir_shift_reg;
      end
    end
  end

  // reserved codes fall to the bypass path as a harmless choice
  always_comb begin
    ins_extest  = 1'b0;
    ins_samplez = 1'b0;
    sel_bsr     = 1'b0;
    sel_id      = 1'b0;
    unique case (test_instruction_reg)
      INS_EXTEST: begin
        ins_extest = 1'b1;
        sel_bsr    = 1'b1;
      end
      INS_IDCODE:   sel_id = 1'b1;
      INS_SAMPLE_Z: begin
        ins_samplez = 1'b1;
        sel_bsr     = 1'b1;
      end
      INS_SAMPLE:   sel_bsr = 1'b1;
      default:      sel_bsr = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // data registers: boundary chain, identification, bypass
  logic [BSR_LEN-1:0] bsr_shift_reg;
  logic [ID_LEN-1:0]  id_shift_reg;
  logic               single_bit_bypass_reg;
  logic               cap_dr;

  assign cap_dr = tck_rise && state_reg == ST_CAP_DR;

  // boundary chain; internal cell is the msb and always captures one
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bsr_shift_reg <= '0;
    end else if (sel_bsr) begin
      if (cap_dr) begin
        bsr_shift_reg <= {INT_CELL_CAP_VAL, io_ring_levels};
      end else if (tck_rise && shift_dr) begin
        bsr_shift_reg <= {sync2_reg.tdi, bsr_shift_reg[BSR_LEN-1:1]};
      end
    end
  end

  // identification register, lsb leaves first
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      id_shift_reg <= ID_CODE;
    end else if (sel_id) begin
      if (cap_dr) begin
        id_shift_reg <= ID_CODE;
      end else if (tck_rise && shift_dr) begin
        id_shift_reg <= {sync2_reg.tdi, id_shift_reg[ID_LEN-1:1]};
      end
    end
  end

  // bypass stage serves every code without its own register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      single_bit_bypass_reg <= BYPASS_CAP_VAL;
    end else if (!sel_bsr && !sel_id) begin
      if (cap_dr) begin
        single_bit_bypass_reg <= BYPASS_CAP_VAL;
      end else if (tck_rise && shift_dr) begin
        single_bit_bypass_reg <= sync2_reg.tdi;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // serial output
  logic tdo_reg;
  logic dr_lsb;

  assign dr_lsb = sel_bsr ? bsr_shift_reg[0] : (sel_id ? id_shift_reg[0] : single_bit_bypass_reg);

  // new bit appears half a tck later, giving the tester a full low phase
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tdo_reg <= 1'b0;
    end else if (tck_fall && (shift_ir || shift_dr)) begin
      tdo_reg <= shift_ir ? ir_shift_reg[0] : dr_lsb;
    end
  end

  assign tdo_out = tdo_reg;
  assign tdo_oe  = shift_ir || shift_dr;

  //////////////////////////////////////////////////////////////////////////////
  // update stage: extest update-dr words are queued to the pin driver; a pending word is overwritten while the queue is full
  logic               upd_pend_reg;
  logic [BSR_LEN-1:0] upd_word_reg;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic [BSR_LEN-1:0] fifo_out_data;
  logic [BSR_LEN-1:0] pin_word_reg;
  logic               upd_set;

  assign upd_set = tck_rise && state_reg == ST_UPD_DR && ins_extest;

  // pending word waits while the queue is full; a new update in a push cycle becomes the next pending word
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      upd_pend_reg <= 1'b0;
      upd_word_reg <= '0;
    end else if (upd_set) begin
      upd_pend_reg <= 1'b1;
      upd_word_reg <= bsr_shift_reg;
    end else if (fifo_in_ready) begin
      upd_pend_reg <= 1'b0;
    end
  end

  jtp_fifo #(
    .WIDTH (BSR_LEN),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_valid  (upd_pend_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (upd_word_reg),
    .out_valid (fifo_out_valid),
    .out_ready (pin_ready),
    .out_data  (fifo_out_data)
  );

  // pin-facing word, internal cell cleared so drivers start disabled
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_word_reg <= '0;
    end else if (fifo_out_valid && pin_ready) begin
      pin_word_reg <= fifo_out_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pad control
  assign boundary_pin_values    = pin_word_reg[BSR_LEN-2:0];
  assign extest_override        = ins_extest;
  assign dq_drive_enable        = ins_extest && pin_word_reg[BSR_LEN-1];
  assign dq_force_hiz           = ins_samplez
                                  || (ins_extest && !pin_word_reg[BSR_LEN-1]);
  assign on_die_termination_off = ins_extest || ins_samplez;
  assign functional_undisturbed = !(ins_extest || ins_samplez);

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  logic [2:0] tms_run_reg;

  // consecutive tck rises seen with tms high, saturating
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tms_run_reg <= '0;
    end else if (tck_rise) begin
      tms_run_reg <= !sync2_reg.tms ? 3'h0 : (tms_run_reg == 3'h7 ? 3'h7 : tms_run_reg + 3'h1);
    end
  end

  sequence s_upd_extest;
    tck_rise && state_reg == ST_UPD_DR && ins_extest;
  endsequence

  sequence s_cap_bypass;
    tck_rise && state_reg == ST_CAP_DR && !sel_bsr && !sel_id;
  endsequence

  a_tms_reset_run: assert property (tms_run_reg >= 3'(TMS_RESET_EDGES) |-> state_reg == ST_RESET)
    else $error("five tms-high edges did not reach reset");
  a_state_on_rise: assert property (!tck_rise |=> $stable(state_reg))
    else $error("state moved without a tck rise");
  a_tdo_enable: assert property (tck_rise && state_next != ST_SHIFT_IR && state_next != ST_SHIFT_DR
                                 |=> !tdo_oe)
    else $error("tdo enabled outside shift");
  a_tdo_on_fall: assert property ($changed(tdo_reg) |-> $past(tck_fall))
    else $error("tdo changed away from a tck fall");
  a_ir_capture: assert property (tck_rise && state_reg == ST_CAP_IR |=> ir_shift_reg == IR_RESET_VAL)
    else $error("capture-ir did not preset idcode");
  a_ir_update: assert property ($changed(test_instruction_reg)
                                |-> $past(state_reg) == ST_UPD_IR || state_reg == ST_RESET)
    else $error("instruction changed outside update-ir");
  a_tdi_ignored: assert property (tck_rise && state_reg == ST_PAUSE_DR |=> $stable(bsr_shift_reg))
    else $error("boundary chain moved outside shift");
  a_id_capture: assert property (cap_dr && sel_id |=> id_shift_reg == ID_CODE)
    else $error("identification code not captured");
  a_bypass_capture: assert property (s_cap_bypass |=> single_bit_bypass_reg == BYPASS_CAP_VAL)
    else $error("bypass stage did not capture zero");
  a_bypass_path: assert property (tck_rise && shift_dr && !sel_bsr && !sel_id
                                  |=> single_bit_bypass_reg == $past(sync2_reg.tdi))
    else $error("bypass stage did not take tdi");
  a_extest_queue: assert property (s_upd_extest |=> upd_pend_reg && upd_word_reg == $past(bsr_shift_reg))
    else $error("update-dr word not queued");
  a_samplez_pads: assert property (ins_samplez |-> dq_force_hiz && on_die_termination_off && !dq_drive_enable)
    else $error("high-impedance sample pads wrong");

endmodule

`default_nettype wire

// ---- testbench/jtp_tester.sv ----
`timescale 1ns/1ps
`default_nettype none

// tester on the far side of the test port; tck stands low between steps
module jtp_tester
  import jtp_pkg::*;
(
  // pacing clock
  input  wire logic ref_clk,
  // serial return
  input  wire logic tdo_out,
  input  wire logic tdo_oe,
  // pins into the port
  output var jtp_pins_t pins
);
  logic last_tdo;
  int   oe_err;

  initial begin
    pins     = '0;
    last_tdo = 1'b0;
    oe_err   = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one 80 ns tck period; tdo read just before the rise, after the fall drove it
  task automatic step(input logic m, input logic d, input logic sh, output logic o);
    pins.tms = m;
    pins.tdi = sh ? d : ~pins.tdi;
    repeat (10) @(posedge ref_clk);
    #1;
    o        = tdo_oe ? tdo_out : ~last_tdo;  // released line never shows its last value
    last_tdo = o;
    if (tdo_oe !== sh) oe_err++;
    pins.tck = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1;
    pins.tck = 1'b0;
  endtask

  // five high tms edges reach reset from anywhere, then park in idle
  task automatic tap_reset();
    logic t;
    repeat (5) step(1'b1, 1'b0, 1'b0, t);
    step(1'b0, 1'b0, 1'b0, t);
  endtask

  // idle, shift-ir, update-ir, idle; lsb first
  task automatic shift_ir(input logic [2:0] code, output logic [2:0] cap);
    logic t;
    step(1'b1, 1'b0, 1'b0, t);
    step(1'b1, 1'b0, 1'b0, t);
    step(1'b0, 1'b0, 1'b0, t);
    step(1'b0, 1'b0, 1'b0, t);
    for (int i = 0; i < 3; i++) begin
      step(i == 2, code[i], 1'b1, t);
      cap[i] = t;
    end
    step(1'b1, 1'b0, 1'b0, t);
    step(1'b0, 1'b0, 1'b0, t);
  endtask

  // full boundary-length shift whatever register is selected
  task automatic shift_dr(input logic [BSR_LEN_DEF-1:0] din, output logic [BSR_LEN_DEF-1:0] dout);
    logic t;
    step(1'b1, 1'b0, 1'b0, t);
    step(1'b0, 1'b0, 1'b0, t);
    step(1'b0, 1'b0, 1'b0, t);
    for (int i = 0; i < BSR_LEN_DEF; i++) begin
      step(i == BSR_LEN_DEF - 1, din[i], 1'b1, t);
      dout[i] = t;
    end
    step(1'b1, 1'b0, 1'b0, t);
    step(1'b0, 1'b0, 1'b0, t);
  endtask

  // capture, then a pause with tdi moving, then update with no shift at all
  task automatic update_only();
    logic t;
    step(1'b1, 1'b0, 1'b0, t);
    step(1'b0, 1'b0, 1'b0, t);
    step(1'b1, 1'b0, 1'b0, t);
    step(1'b0, 1'b0, 1'b0, t);
    step(1'b1, 1'b0, 1'b0, t);
    step(1'b1, 1'b0, 1'b0, t);
    step(1'b0, 1'b0, 1'b0, t);
  endtask
endmodule

`default_nettype wire

// ---- testbench/tb_jtag_tap_controller.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_jtag_tap_controller;
  import jtp_pkg::*;

  localparam int          BL = BSR_LEN_DEF;
  localparam logic [31:0] ID = 32'h0a5c_3e71;  // arbitrary value, bit 0 set

  logic          ref_clk;
  logic          sys_rst;
  jtp_pins_t     pins;
  logic          tdo_out;
  logic          tdo_oe;
  logic [BL-2:0] io_ring;
  logic          pin_ready;
  logic [BL-2:0] pin_vals;
  logic          ext_ov;
  logic          dq_en;
  logic          dq_hiz;
  logic          odt_off;
  logic          func_ok;
  int            error_cnt;
  int            compares;
  logic [2:0]    cap;
  logic [BL-1:0] din;
  logic [BL-1:0] dout;
  logic [BL-1:0] exp_dr;
  logic [BL-2:0] last_word;
  logic          t;
  logic          ext;
  logic          sz;
  logic [2:0]    codes [5];

  jtp_tap #(.BSR_LEN(BL), .FIFO_DEPTH(FIFO_DEPTH_DEF), .ID_CODE(ID)) u_dut (
    .ref_clk                (ref_clk),
    .sys_rst                (sys_rst),
    .tck_pin                (pins.tck),
    .tms_pin                (pins.tms),
    .tdi_pin                (pins.tdi),
    .tdo_out                (tdo_out),
    .tdo_oe                 (tdo_oe),
    .io_ring_levels         (io_ring),
    .pin_ready              (pin_ready),
    .boundary_pin_values    (pin_vals),
    .extest_override        (ext_ov),
    .dq_drive_enable        (dq_en),
    .dq_force_hiz           (dq_hiz),
    .on_die_termination_off (odt_off),
    .functional_undisturbed (func_ok)
  );

  jtp_tester u_tester (
    .ref_clk (ref_clk),
    .tdo_out (tdo_out),
    .tdo_oe  (tdo_oe),
    .pins    (pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 250 mhz system clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic check(input string name, input logic [BL-1:0] seen, input logic [BL-1:0] expv);
    compares++;
    if (seen !== expv) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, expv, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  function automatic logic [BL-2:0] pat(input int j);
    return {8{16'h3c00 ^ 16'(j)}};
  endfunction

  // one-cycle drain request, then let the pin word settle
  task automatic pulse_ready();
    @(posedge ref_clk);
    #1 pin_ready = 1'b1;
    @(posedge ref_clk);
    #1 pin_ready = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  task automatic sys_reset();
    sys_rst = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    check("pins", pin_vals, '0);
    check("flags", {ext_ov, odt_off, dq_hiz, dq_en, func_ok}, 5'h01);
    check("tdo_oe", tdo_oe, 1'b0);
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    error_cnt++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    error_cnt = 0;
    compares  = 0;
    io_ring   = '0;
    pin_ready = 1'b0;
    last_word = '0;
    codes     = '{INS_EXTEST, INS_SAMPLE_Z, INS_SAMPLE, INS_IDCODE, INS_BYPASS};
    sys_reset();
    $display("test reset done");

    // every instruction: flags, capture and shift path, pin effect
    u_tester.tap_reset();
    pin_ready = 1'b1;
    for (int k = 0; k < 5; k++) begin
      ext = (codes[k] === INS_EXTEST);
      sz  = (codes[k] === INS_SAMPLE_Z);
      u_tester.shift_ir(codes[k], cap);
      check("ir capture", cap, IR_RESET_VAL);
      check("flags", {ext_ov, odt_off, dq_hiz, dq_en, func_ok}, {ext, ext | sz, ext | sz, 1'b0, ~(ext | sz)});
      io_ring = {4{32'h5a0f_33c1 ^ 32'(k)}};
      din     = {1'b1, {4{32'hc3a5_0f96 ^ 32'(k)}}};
      u_tester.shift_dr(din, dout);
      if (ext | sz | (codes[k] === INS_SAMPLE)) exp_dr = {1'b1, io_ring};
      else if (codes[k] === INS_IDCODE) exp_dr = {din[96:0], ID};
      else exp_dr = {din[127:0], 1'b0};
      check("dr out", dout, exp_dr);
      if (ext) last_word = din[BL-2:0];
      check("pins", pin_vals, last_word);
      check("drive", {dq_en, dq_hiz}, {ext, sz});
      check("oe faults", u_tester.oe_err, 0);
      $display("test mode %h done", codes[k]);
    end

    // queue fills while the pin stage stalls, newest pending word wins
    pin_ready = 1'b0;
    u_tester.shift_ir(INS_EXTEST, cap);
    for (int j = 0; j < 18; j++) begin
      io_ring = pat(j);
      u_tester.update_only();
    end
    check("stalled pins", pin_vals, last_word);
    for (int j = 0; j < 17; j++) begin
      pulse_ready();
      check("queued pins", pin_vals, pat(j < 16 ? j : 17));
    end
    pulse_ready();
    check("drained pins", pin_vals, pat(17));
    check("drive", {dq_en, dq_hiz}, 2'h2);
    $display("test queue done");

    // four high tms edges from shift-dr keep the instruction, the fifth resets
    u_tester.step(1'b1, 1'b0, 1'b0, t);
    u_tester.step(1'b0, 1'b0, 1'b0, t);
    u_tester.step(1'b0, 1'b0, 1'b0, t);
    for (int i = 0; i < 4; i++) u_tester.step(1'b1, 1'b0, i == 0, t);
    check("four ones", ext_ov, 1'b1);
    u_tester.step(1'b1, 1'b0, 1'b0, t);
    check("five ones", {ext_ov, odt_off, func_ok}, 3'h1);
    u_tester.step(1'b0, 1'b0, 1'b0, t);
    $display("test tms reset done");

    // power-up again in mid-run: identification code selected with no load
    sys_reset();
    u_tester.step(1'b0, 1'b0, 1'b0, t);
    din = {4{32'h96e1_7b2d}};
    u_tester.shift_dr(din, dout);
    check("id after reset", dout, {din[96:0], ID});
    check("oe faults", u_tester.oe_err, 0);
    $display("test power-up id done");
    report_and_stop();
  end
endmodule

`default_nettype wire
